// ===== logic/speech_ctrl_regs.vh
// Register addresses, reset values, field positions and timing counts of the speech register file
`ifndef SPEECH_CTRL_REGS_VH
`define SPEECH_CTRL_REGS_VH

// =========================================================
// Register select codes on the load port
`define REG_LED_CFG      4'h0
`define REG_PAGE         4'h1
`define REG_EN_PRI       4'h2
`define REG_EN_SEC       4'h3
`define REG_STOP         4'h4
`define REG_GEN0         4'h5
`define REG_GEN1         4'h6
`define REG_GEN2         4'h7
`define REG_GEN3         4'h8

// =========================================================
// Reset values
`define RST_GEN          8'h20
`define RST_EN           8'h33
`define RST_LED_CFG      8'hFF
`define RST_STOP         8'h1F
`define RST_PAGE         8'h00

// =========================================================
// Field positions
`define LED_ALT_BIT      5
`define LAMP_ONE_SECT_BIT    4
`define LAMP_TWO_SECT_BIT    3
`define LAMP_ONE_VOL_BIT     2
`define EN_FALL_A_BIT    0
`define EN_FALL_B_BIT    1
`define EN_RISE_A_BIT    4
`define EN_RISE_B_BIT    5

// =========================================================
// Page mode option codes
`define PMODE_1          2'h0
`define PMODE_8          2'h1
`define PMODE_16         2'h2
`define PMODE_32         2'h3

// =========================================================
// Vector numbers
`define VEC_FALL_A       8'h00
`define VEC_FALL_B       8'h01
`define VEC_FALL_C       8'h08
`define VEC_FALL_D       8'h09
`define VEC_RISE_A       8'h04
`define VEC_RISE_B       8'h05
`define VEC_RISE_C       8'h0C
`define VEC_RISE_D       8'h0D
`define VEC_FALL_C4      8'h02
`define VEC_FALL_D4      8'h03
`define VEC_RISE_C4      8'h06
`define VEC_RISE_D4      8'h07
`define VEC_POI          8'h20

// =========================================================
// Timing: power-on delay in microseconds, clock period in nanoseconds
`define POI_DELAY_US     160000
`define CLK_PERIOD_NS    8
`define POI_DELAY_CYC    ((`POI_DELAY_US * 1000) / `CLK_PERIOD_NS)
`define FLASH_HALF_CYC   20833333

`endif

// ===== logic/general_reg_bank.v
// Four 8-bit voice entry registers with registered read port
`timescale 1ns/100ps
`default_nettype none
`include "speech_ctrl_regs.vh"
module general_reg_bank (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       wr_en,
  input  wire [1:0] wr_sel,
  input  wire [7:0] wr_data,
  input  wire       inc_en,
  input  wire [1:0] rd_sel,
  output reg  [7:0] rd_data
);
  reg [7:0] mem [0:3];
  integer   i;

  // =========================================================
  // Storage, load and increment
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < 4; i = i + 1) begin
        mem[i] <= `RST_GEN;
      end
    end else begin
      if (wr_en) begin
        mem[wr_sel] <= wr_data;
      end
      if (inc_en && !(wr_en && wr_sel == 2'd0)) begin
        mem[0] <= mem[0] + 8'h01;
      end
    end
  end

  // Registered read
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= mem[rd_sel];
    end
  end
endmodule
`default_nettype wire

// ===== logic/trigger_edge_detect.v
// Edge detector for one trigger pin with per-edge enables
`timescale 1ns/100ps
`default_nettype none
module trigger_edge_detect (
  input  wire clk,
  input  wire rst_n,
  input  wire pin,
  input  wire fall_en,
  input  wire rise_en,
  output reg  fall_req,
  output reg  rise_req
);
  reg last;

  // =========================================================
  // Previous level and gated edge pulses
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last     <= 1'b1;                         // Pins idle high
      fall_req <= 1'b0;
      rise_req <= 1'b0;
    end else begin
      last     <= pin;
      fall_req <= last & ~pin & fall_en;
      rise_req <= ~last & pin & rise_en;
    end
  end
endmodule
`default_nettype wire

// ===== logic/speech_ctrl_register_file.v
// Special-purpose register file and trigger-to-vector dispatch of the speech controller
`timescale 1ns/100ps
`default_nettype none
`include "speech_ctrl_regs.vh"
module speech_ctrl_register_file #(
  parameter [1:0]  PAGE_MODE   = `PMODE_1,      // Fixed page mode option
  parameter        CPU_MODE    = 0,             // 1 selects serial CPU mode
  parameter        FAST_OSC    = 1,             // 1: 3 MHz, 0: 1.5 MHz system clock
  parameter        PWM_OUT     = 0,             // 1: PWM voice, 0: DAC voice
  parameter        SIX_TRIG    = 1,             // 1: six-trigger vector map
  parameter [31:0] POI_CYCLES  = `POI_DELAY_CYC,
  parameter [31:0] FLASH_CYCLES = `FLASH_HALF_CYC
) (
  input  wire       ref_clk,
  input  wire       rst_b,
  input  wire       load_instr,
  input  wire [3:0] load_sel,
  input  wire [7:0] load_data,
  input  wire       inc_instr,
  input  wire       jump_req,
  input  wire [7:0] jump_vector,
  input  wire [1:0] rd_gen_sel,
  input  wire       trigger_a,
  input  wire       trigger_b,
  input  wire       trigger_c,
  input  wire       trigger_d,
  input  wire       section_led,
  input  wire       volume_active,
  input  wire       vector_ack,
  output reg  [7:0] gen_rd_data,
  output reg        vector_valid,
  output reg  [7:0] vector_num,
  output reg  [4:0] working_page,
  output reg  [7:0] vectors_per_page,
  output reg        interrupt_pulse,
  output reg  [4:0] stop_levels,
  output reg        lamp_one,
  output reg        lamp_two,
  output reg        cpu_mode_sel,
  output reg        fast_osc_option,
  output reg        pwm_out_sel
);
  // =========================================================
  // Reset release
  reg rst_s1;
  reg rst_n;
  // Assert at once, release two edges after the pin rises
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // =========================================================
  // Helpers
  function [4:0] page_mask;
    input [1:0] mode;
    begin
      case (mode)
        `PMODE_8:  page_mask = 5'h07;
        `PMODE_16: page_mask = 5'h0F;
        `PMODE_32: page_mask = 5'h1F;
        default:   page_mask = 5'h00;
      endcase
    end
  endfunction

  function [7:0] per_page;
    input [1:0] mode;
    begin
      case (mode)
        `PMODE_16: per_page = 8'h80;
        `PMODE_32: per_page = 8'h40;
        default:   per_page = 8'h00;            // 256 wraps to zero in 8 bits
      endcase
    end
  endfunction

  // Vector of trigger C or D for the fitted trigger count
  function [7:0] pick_vec;
    input [7:0] six_vec;
    input [7:0] four_vec;
    begin
      pick_vec = (SIX_TRIG != 0) ? six_vec : four_vec;
    end
  endfunction

  // =========================================================
  // Special registers
  reg [7:0] led_behaviour_config;
  reg [7:0] page_select;
  reg [7:0] edge_enable_primary;
  reg [7:0] edge_enable_secondary;
  reg [7:0] stop_output_levels;
  // General register loads go to the bank, not to this process
  wire      gen_wr = load_instr && load_sel >= `REG_GEN0 && load_sel <= `REG_GEN3;
  wire [3:0] gen_off = load_sel - `REG_GEN0;

  // Loads from the sequencer; don't-care bits stored as written
  // Selects past the last general register change nothing
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      led_behaviour_config  <= `RST_LED_CFG;
      page_select           <= `RST_PAGE;
      edge_enable_primary   <= `RST_EN;
      edge_enable_secondary <= `RST_EN;
      stop_output_levels    <= `RST_STOP;
    end else if (load_instr) begin
      case (load_sel)
        `REG_LED_CFG: led_behaviour_config  <= load_data;
        `REG_PAGE:    page_select           <= load_data;
        `REG_EN_PRI:  edge_enable_primary   <= load_data;
        `REG_EN_SEC:  edge_enable_secondary <= load_data;
        `REG_STOP:    stop_output_levels    <= load_data;
        default: ;
      endcase
    end
  end

  // General registers; read data registered inside the bank
  wire [7:0] gen_rd_data_w;
  general_reg_bank u_gen (
    .clk     (ref_clk),
    .rst_n   (rst_n),
    .wr_en   (gen_wr),
    .wr_sel  (gen_off[1:0]),
    .wr_data (load_data),
    .inc_en  (inc_instr),
    .rd_sel  (rd_gen_sel),
    .rd_data (gen_rd_data_w)
  );

  // =========================================================
  // Trigger edges
  // One pulse per enabled edge; a disabled edge never leaves its detector
  wire fa, ra, fb, rb, fc, rc, fd, rd;
  trigger_edge_detect u_ta (
    .clk      (ref_clk),
    .rst_n    (rst_n),
    .pin      (trigger_a),
    .fall_en  (edge_enable_primary[`EN_FALL_A_BIT]),
    .rise_en  (edge_enable_primary[`EN_RISE_A_BIT]),
    .fall_req (fa),
    .rise_req (ra)
  );
  trigger_edge_detect u_tb (
    .clk      (ref_clk),
    .rst_n    (rst_n),
    .pin      (trigger_b),
    .fall_en  (edge_enable_primary[`EN_FALL_B_BIT]),
    .rise_en  (edge_enable_primary[`EN_RISE_B_BIT]),
    .fall_req (fb),
    .rise_req (rb)
  );
  trigger_edge_detect u_tc (
    .clk      (ref_clk),
    .rst_n    (rst_n),
    .pin      (trigger_c),
    .fall_en  (edge_enable_secondary[`EN_FALL_A_BIT]),
    .rise_en  (edge_enable_secondary[`EN_RISE_A_BIT]),
    .fall_req (fc),
    .rise_req (rc)
  );
  trigger_edge_detect u_td (
    .clk      (ref_clk),
    .rst_n    (rst_n),
    .pin      (trigger_d),
    .fall_en  (edge_enable_secondary[`EN_FALL_B_BIT]),
    .rise_en  (edge_enable_secondary[`EN_RISE_B_BIT]),
    .fall_req (fd),
    .rise_req (rd)
  );

  // =========================================================
  // Power-on delay and dispatch state machine
  localparam [2:0] ST_WAIT = 3'b001;
  localparam [2:0] ST_IDLE = 3'b010;
  localparam [2:0] ST_HOLD = 3'b100;
  // Wait runs the power-on delay; hold keeps a vector up until it is taken
  reg [2:0]  state;
  reg [31:0] poi_cnt;
  reg [7:0]  next_vec;
  reg        next_hit;

  // Priority selection of pending sources
  // Fixed order: trigger A fall first, jump last
  always @* begin
    next_hit = 1'b1;
    if (fa)            next_vec = `VEC_FALL_A;
    else if (ra)       next_vec = `VEC_RISE_A;
    else if (fb)       next_vec = `VEC_FALL_B;
    else if (rb)       next_vec = `VEC_RISE_B;
    else if (fc)       next_vec = pick_vec(`VEC_FALL_C, `VEC_FALL_C4);
    else if (rc)       next_vec = pick_vec(`VEC_RISE_C, `VEC_RISE_C4);
    else if (fd)       next_vec = pick_vec(`VEC_FALL_D, `VEC_FALL_D4);
    else if (rd)       next_vec = pick_vec(`VEC_RISE_D, `VEC_RISE_D4);
    else if (jump_req) next_vec = jump_vector;
    else begin
      next_vec = 8'h00;
      next_hit = 1'b0;
    end
  end

  // Vector dispatch; a new edge or jump preempts a held vector other than the power-on one
  // Edge requests last one cycle, so one not taken at once is lost
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state           <= ST_WAIT;
      poi_cnt         <= 32'h0;
      vector_valid    <= 1'b0;
      vector_num      <= 8'h00;
      interrupt_pulse <= 1'b0;
    end else begin
      interrupt_pulse <= 1'b0;
      case (state)
        ST_WAIT: begin
          if (poi_cnt >= POI_CYCLES - 32'h1) begin
            vector_valid    <= 1'b1;
            vector_num      <= `VEC_POI;
            interrupt_pulse <= 1'b1;
            state           <= ST_HOLD;
          end else begin
            poi_cnt <= poi_cnt + 32'h1;
          end
        end
        ST_IDLE: begin
          if (next_hit) begin
            vector_valid    <= 1'b1;
            vector_num      <= next_vec;
            interrupt_pulse <= 1'b1;
            state           <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          // Power-on vector is never preempted; any other is
          if (next_hit && vector_num != `VEC_POI) begin
            vector_num      <= next_vec;
            interrupt_pulse <= 1'b1;
          end else if (vector_ack) begin
            vector_valid <= 1'b0;
            state        <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // =========================================================
  // Lamp flash timebase
  reg [31:0] flash_cnt;
  reg        flash_ph;
  // Phase flips every half period; both lamps share it
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_cnt <= 32'h0;
      flash_ph  <= 1'b0;
    end else if (flash_cnt >= FLASH_CYCLES - 32'h1) begin
      flash_cnt <= 32'h0;
      flash_ph  <= ~flash_ph;
    end else begin
      flash_cnt <= flash_cnt + 32'h1;
    end
  end

  // =========================================================
  // Registered outputs
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gen_rd_data      <= 8'h00;
      working_page     <= 5'h00;
      vectors_per_page <= 8'h00;
      stop_levels      <= 5'h00;
      lamp_one         <= 1'b0;
      lamp_two         <= 1'b0;
      cpu_mode_sel     <= 1'b0;
      fast_osc_option  <= 1'b0;
      pwm_out_sel      <= 1'b0;
    end else begin
      gen_rd_data      <= gen_rd_data_w;
      // Page bits beyond the mode's width are masked off here
      working_page     <= page_select[4:0] & page_mask(PAGE_MODE);
      vectors_per_page <= per_page(PAGE_MODE);
      stop_levels      <= stop_output_levels[4:0];
      // Lamp one follows the flash phase unless section or volume holds it off
      lamp_one <= flash_ph
                  & (~led_behaviour_config[`LAMP_ONE_SECT_BIT] | section_led)
                  & (~led_behaviour_config[`LAMP_ONE_VOL_BIT] | ~volume_active);
      // Lamp two in phase or antiphase, lit from section control or stop C
      lamp_two <= (led_behaviour_config[`LED_ALT_BIT] ? ~flash_ph : flash_ph)
                  & (led_behaviour_config[`LAMP_TWO_SECT_BIT] ? section_led
                                                          : stop_output_levels[2]);
      // Build-time options reflected for the rest of the device
      cpu_mode_sel     <= (CPU_MODE != 0);
      fast_osc_option  <= (FAST_OSC != 0);
      pwm_out_sel      <= (PWM_OUT != 0);
    end
  end
  // Options are parameters only; no load reaches them
endmodule
`default_nettype wire

// ===== verif/speech_ctrl_register_file_assertions.sv
// Port checker for the speech register file
`timescale 1ns/100ps
`default_nettype none
module speech_ctrl_checker #(
  parameter [1:0]  PAGE_MODE  = 2'h0,
  parameter        CPU_MODE   = 0,
  parameter        FAST_OSC   = 1,
  parameter        PWM_OUT    = 0,
  parameter [31:0] POI_CYCLES = 32'd20
) (
  input wire logic       ref_clk,
  input wire logic       rst_b,
  input wire logic       load_instr,
  input wire logic [3:0] load_sel,
  input wire logic [7:0] load_data,
  input wire logic       inc_instr,
  input wire logic [1:0] rd_gen_sel,
  input wire logic       trigger_a,
  input wire logic [7:0] gen_rd_data,
  input wire logic       vector_valid,
  input wire logic       vector_ack,
  input wire logic [7:0] vector_num,
  input wire logic [4:0] working_page,
  input wire logic [7:0] vectors_per_page,
  input wire logic       interrupt_pulse,
  input wire logic [4:0] stop_levels,
  input wire logic       cpu_mode_sel,
  input wire logic       fast_osc_option,
  input wire logic       pwm_out_sel
);
  localparam logic [4:0] PMASK = PAGE_MODE == 2'h3 ? 5'h1F : PAGE_MODE == 2'h2 ? 5'h0F :
                                 PAGE_MODE == 2'h1 ? 5'h07 : 5'h00;
  localparam logic [7:0] VPP   = PAGE_MODE == 2'h3 ? 8'h40 : PAGE_MODE == 2'h2 ? 8'h80 : 8'h00;
  logic [7:0]  stop_sh, page_sh, en_sh;
  logic [7:0]  gen_sh [0:3];
  logic [3:0]  quiet;
  logic [1:0]  sel_d1, sel_d2;
  logic [31:0] run_cnt;
  logic        poi_seen;

  // ==========
  // Shadow copies of the loaded registers and quiet-time counter
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stop_sh  <= 8'h1F;
      page_sh  <= 8'h00;
      en_sh    <= 8'h33;
      for (int i = 0; i < 4; i++) gen_sh[i] <= 8'h20;
      quiet    <= 4'h0;
      sel_d1   <= 2'h0;
      sel_d2   <= 2'h0;
      run_cnt  <= 32'h0;
      poi_seen <= 1'b0;
    end else begin
      quiet    <= (load_instr || inc_instr) ? 4'h0 : (quiet == 4'hF ? quiet : quiet + 4'h1);
      sel_d1   <= rd_gen_sel;
      sel_d2   <= sel_d1;
      run_cnt  <= poi_seen ? run_cnt : run_cnt + 32'h1;
      poi_seen <= poi_seen | interrupt_pulse;
      if (inc_instr && !(load_instr && load_sel == 4'h5)) gen_sh[0] <= gen_sh[0] + 8'h01;
      if (load_instr) begin
        case (load_sel)
          4'h1: page_sh <= load_data;
          4'h2: en_sh <= load_data;
          4'h4: stop_sh <= load_data;
          4'h5, 4'h6, 4'h7, 4'h8: gen_sh[load_sel - 4'h5] <= load_data;
          default: ;
        endcase
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // ==========
  // Vector dispatch
  chk_pulse_valid: assert property (interrupt_pulse |-> vector_valid)
    else $error("pulse without a valid vector");
  chk_valid_hold: assert property (vector_valid && !vector_ack |=> vector_valid)
    else $error("vector dropped before acknowledge");
  chk_fall_vec: assert property ($fell(trigger_a) && en_sh[0] && quiet > 4'h0 && poi_seen
    && !(vector_valid && vector_num == 8'h20) |-> ##[1:3] (interrupt_pulse && vector_num == 8'h00))
    else $error("first trigger fall did not give vector zero");
  chk_poi_first: assert property (!poi_seen && interrupt_pulse |-> vector_num == 8'h20)
    else $error("first vector after reset is not power-on");
  chk_poi_bound: assert property (run_cnt == POI_CYCLES + 32'd8 |-> poi_seen)
    else $error("power-on vector late");

  // ==========
  // Register reflections
  chk_stop_map: assert property (quiet > 4'h4 |-> stop_levels == stop_sh[4:0])
    else $error("stop levels differ from stop register");
  chk_page_mask: assert property (quiet > 4'h4 |-> working_page == (page_sh[4:0] & PMASK))
    else $error("working page mask wrong");
  chk_vpp_fixed: assert property (quiet > 4'h4 |-> vectors_per_page == VPP)
    else $error("vectors per page wrong");
  chk_gen_read: assert property (quiet > 4'h4 && rd_gen_sel == sel_d1 && sel_d1 == sel_d2
    |-> gen_rd_data == gen_sh[rd_gen_sel])
    else $error("general register read wrong");
  chk_options_fixed: assert property (quiet > 4'h4 |-> cpu_mode_sel == (CPU_MODE != 0)
    && fast_osc_option == (FAST_OSC != 0) && pwm_out_sel == (PWM_OUT != 0))
    else $error("option reflection wrong");
endmodule

bind speech_ctrl_register_file speech_ctrl_checker #(.PAGE_MODE(PAGE_MODE), .CPU_MODE(CPU_MODE),
  .FAST_OSC(FAST_OSC), .PWM_OUT(PWM_OUT), .POI_CYCLES(POI_CYCLES)) speech_ctrl_checker_inst (
  .ref_clk(ref_clk), .rst_b(rst_b), .load_instr(load_instr), .load_sel(load_sel),
  .load_data(load_data), .inc_instr(inc_instr), .rd_gen_sel(rd_gen_sel), .trigger_a(trigger_a),
  .gen_rd_data(gen_rd_data), .vector_valid(vector_valid), .vector_ack(vector_ack),
  .vector_num(vector_num), .working_page(working_page), .vectors_per_page(vectors_per_page),
  .interrupt_pulse(interrupt_pulse), .stop_levels(stop_levels), .cpu_mode_sel(cpu_mode_sel),
  .fast_osc_option(fast_osc_option), .pwm_out_sel(pwm_out_sel));
`default_nettype wire

// ===== verif/trigger_seq_model.sv
// Trigger pins and sequencer acknowledge model
`timescale 1ns/100ps
`default_nettype none
module trigger_seq_model (
  input  wire logic       clk,
  input  wire logic [3:0] pin_req,
  input  wire logic [3:0] ack_delay,
  input  wire logic       vector_valid,
  output var  logic [3:0] pins,
  output var  logic       vector_ack
);
  logic [3:0] wait_cnt;

  // ==========
  // Pins idle high; ack raised after a chosen delay, held one cycle
  initial begin
    pins = 4'hF;
    vector_ack = 1'b0;
    wait_cnt = 4'h0;
  end
  always @(negedge clk) begin
    pins <= pin_req;
    if (vector_valid === 1'b1 && !vector_ack && wait_cnt >= ack_delay) begin
      vector_ack <= 1'b1;
      wait_cnt <= 4'h0;
    end else if (vector_valid === 1'b1 && !vector_ack) begin
      wait_cnt <= wait_cnt + 4'h1;
    end else begin
      vector_ack <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== verif/test_speech_ctrl_register_file.sv
// Self-checking bench for the speech register file
`timescale 1ns/100ps
`default_nettype none
`include "speech_ctrl_regs.vh"
module test_speech_ctrl_register_file;
  logic       ref_clk, rst_b, load_instr, inc_instr, jump_req, section_led, volume_active;
  logic       vector_ack, vector_valid, interrupt_pulse, lamp_one, lamp_two, seen;
  logic       cpu_mode_sel, fast_osc_option, pwm_out_sel;
  logic [3:0] load_sel, pin_req, ack_delay, pins;
  logic [7:0] load_data, jump_vector, gen_rd_data, vector_num, vectors_per_page, d;
  logic [1:0] rd_gen_sel;
  logic [4:0] working_page, stop_levels;
  logic [7:0] got [$];
  int         fail_count, cmp_count, cycles, i, k, ones, bad1, bad2;

  speech_ctrl_register_file #(.PAGE_MODE(`PMODE_16), .FAST_OSC(0), .PWM_OUT(1),
    .POI_CYCLES(32'd20), .FLASH_CYCLES(32'd4)) speech_ctrl_register_file_inst (
    .ref_clk(ref_clk), .rst_b(rst_b), .load_instr(load_instr), .load_sel(load_sel),
    .load_data(load_data), .inc_instr(inc_instr), .jump_req(jump_req),
    .jump_vector(jump_vector), .rd_gen_sel(rd_gen_sel), .trigger_a(pins[0]),
    .trigger_b(pins[1]), .trigger_c(pins[2]), .trigger_d(pins[3]), .section_led(section_led),
    .volume_active(volume_active), .vector_ack(vector_ack), .gen_rd_data(gen_rd_data),
    .vector_valid(vector_valid), .vector_num(vector_num), .working_page(working_page),
    .vectors_per_page(vectors_per_page), .interrupt_pulse(interrupt_pulse),
    .stop_levels(stop_levels), .lamp_one(lamp_one), .lamp_two(lamp_two),
    .cpu_mode_sel(cpu_mode_sel), .fast_osc_option(fast_osc_option), .pwm_out_sel(pwm_out_sel));

  trigger_seq_model trigger_seq_model_inst (.clk(ref_clk), .pin_req(pin_req),
    .ack_delay(ack_delay), .vector_valid(vector_valid), .pins(pins), .vector_ack(vector_ack));

  // ==========
  // Clock, vector log and hang limit
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (interrupt_pulse === 1'b1) got.push_back(vector_num);
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      $display("ERROR %0t: timeout", $time);
      conclude();
    end
  end

  // ==========
  // Helpers
  function automatic logic [7:0] exp_vec(input int p, input bit rise);
    logic [7:0] fall_v [4] = '{8'h00, 8'h01, 8'h08, 8'h09};
    return fall_v[p] + (rise ? 8'h04 : 8'h00);
  endfunction
  task automatic chk8(input logic [7:0] act, input logic [7:0] exp);
    cmp_count++;
    if (act !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, act, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic load(input logic [3:0] s, input logic [7:0] v);
    @(negedge ref_clk);
    load_sel = s;
    load_data = v;
    load_instr = 1'b1;
    @(negedge ref_clk);
    load_instr = 1'b0;
  endtask
  task automatic toggle(input int p, input logic lvl);
    @(negedge ref_clk);
    pin_req[p] = lvl;
    idle(6);
  endtask
  task automatic watch_lamp2;
    seen = 1'b0;
    repeat (16) begin
      @(negedge ref_clk);
      seen = seen | lamp_two;
      section_led = 1'($urandom);
      volume_active = 1'($urandom);
    end
  endtask
  task automatic watch_lamps(input logic [7:0] cfg, output int ones, output int bad1,
                             output int bad2);
    logic sec, vol, gate;
    ones = 0;
    bad1 = 0;
    bad2 = 0;
    load(`REG_LED_CFG, cfg);
    idle(2);
    sec = section_led;
    vol = volume_active;
    repeat (16) begin
      @(negedge ref_clk);
      gate = !(cfg[4] && !sec) && !(cfg[2] && vol);
      ones = ones + int'(lamp_one);
      if (lamp_one !== 1'b0 && !gate) bad1++;
      if (lamp_two !== 1'b0 && cfg[3] && !sec) bad2++;
      if (gate && !cfg[3] && lamp_two !== (cfg[5] ? ~lamp_one : lamp_one)) bad2++;
      section_led = 1'($urandom);
      volume_active = 1'($urandom);
      sec = section_led;
      vol = volume_active;
    end
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ==========
  // Main sequence
  initial begin
    {rst_b, load_instr, inc_instr, jump_req, section_led, volume_active} = 6'h00;
    {load_sel, load_data, jump_vector, rd_gen_sel, ack_delay} = 26'h0;
    pin_req = 4'hF;
    fail_count = 0;
    cmp_count = 0;
    cycles = 0;
    void'($urandom(32'h46e497bf));
    repeat (3) @(negedge ref_clk);
    rst_b = 1'b1;
    idle(30);
    chk8(8'(got.size()), 8'h01);
    chk8(got[0], 8'h20);
    chk8({3'h0, stop_levels}, 8'h1F);
    chk8({3'h0, working_page}, 8'h00);
    chk8(vectors_per_page, 8'h80);
    chk8({5'h0, cpu_mode_sel, fast_osc_option, pwm_out_sel}, 8'h01);
    for (i = 0; i < 4; i++) begin
      rd_gen_sel = 2'(i);
      idle(4);
      chk8(gen_rd_data, 8'h20);
    end
    $display("reset and power-on test done");
    repeat (12) begin
      d = 8'($urandom);
      k = $urandom % 4;
      load(`REG_STOP, d);
      load(`REG_PAGE, d);
      load(4'(`REG_GEN0 + k), ~d);
      load(4'hF, 8'h00);
      rd_gen_sel = 2'(k);
      idle(5);
      chk8({3'h0, stop_levels}, {3'h0, d[4:0]});
      chk8({3'h0, working_page}, {4'h0, d[3:0]});
      chk8(gen_rd_data, ~d);
    end
    $display("register load test done");
    load(`REG_GEN0, 8'hFF);
    load(`REG_GEN1, 8'h55);
    @(negedge ref_clk);
    inc_instr = 1'b1;
    @(negedge ref_clk);
    inc_instr = 1'b0;
    rd_gen_sel = 2'h0;
    idle(5);
    chk8(gen_rd_data, 8'h00);
    rd_gen_sel = 2'h1;
    idle(5);
    chk8(gen_rd_data, 8'h55);
    $display("increment test done");
    for (i = 0; i < 4; i++) begin
      ack_delay = 4'($urandom % 4);
      load(`REG_EN_PRI, 8'h00);
      load(`REG_EN_SEC, 8'h00);
      load(i < 2 ? `REG_EN_PRI : `REG_EN_SEC, 8'h11 << (i % 2));
      got.delete();
      toggle(i, 1'b0);
      toggle(i, 1'b1);
      chk8(8'(got.size()), 8'h02);
      chk8(got[0], exp_vec(i, 1'b0));
      chk8(got[1], exp_vec(i, 1'b1));
      load(i < 2 ? `REG_EN_PRI : `REG_EN_SEC, 8'hCC);
      got.delete();
      toggle(i, 1'b0);
      toggle(i, 1'b1);
      chk8(8'(got.size()), 8'h00);
    end
    $display("edge enable test done");
    load(`REG_EN_PRI, 8'h33);
    got.delete();
    @(negedge ref_clk);
    pin_req = 4'hC;
    idle(8);
    chk8(got[0], 8'h00);
    pin_req = 4'hF;
    idle(8);
    got.delete();
    d = 8'($urandom);
    jump_vector = d;
    jump_req = 1'b1;
    for (k = 0; k < 10 && got.size() == 0; k++) @(negedge ref_clk);
    jump_req = 1'b0;
    chk8(got[0], d);
    $display("priority and jump test done");
    load(`REG_LED_CFG, 8'h00);
    load(`REG_STOP, 8'h00);
    watch_lamp2();
    chk8({7'h0, seen}, 8'h00);
    load(`REG_STOP, 8'h04);
    watch_lamp2();
    chk8({7'h0, seen}, 8'h01);
    for (i = 0; i < 6; i++) begin
      d = i == 0 ? 8'h00 : i == 1 ? 8'h20 : i == 2 ? 8'h14 : 8'($urandom);
      watch_lamps(d, ones, bad1, bad2);
      chk8(8'(bad1), 8'h00);
      chk8(8'(bad2), 8'h00);
      if (i < 2) chk8({7'h0, ones > 0}, 8'h01);
    end
    $display("lamp test done");
    conclude();
  end
endmodule
`default_nettype wire
